// *** src/gsr_pkg.sv ***
// shared constants and types of the global interrupt shared register block
package gsr_pkg;
  localparam int NUM_SRC = 32;
  localparam int NUM_VP = 4;
  localparam int NUM_LINES = 6;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;
  // register byte offsets
  localparam logic [15:0] OFS_CONFIG = 16'h0000;
  localparam logic [15:0] OFS_CNT_LO = 16'h0010;
  localparam logic [15:0] OFS_CNT_HI = 16'h0014;
  localparam logic [15:0] OFS_REVISION = 16'h0020;
  localparam logic [15:0] OFS_POLARITY = 16'h0100;
  localparam logic [15:0] OFS_TRIGGER = 16'h0180;
  localparam logic [15:0] OFS_DUAL_EDGE = 16'h0200;
  localparam logic [15:0] OFS_EDGE_MSG = 16'h0280;
  localparam logic [15:0] OFS_MASK_CLR = 16'h0300;
  localparam logic [15:0] OFS_MASK_SET = 16'h0380;
  localparam logic [15:0] OFS_MASK_STAT = 16'h0400;
  localparam logic [15:0] OFS_PENDING = 16'h0480;
  localparam logic [15:0] OFS_DEBUG_SEND = 16'h0700;
  // route tables, one word per source, selected by addr[15:7]
  localparam logic [8:0] PAGE_PIN_ROUTE = 9'h00a;
  localparam logic [8:0] PAGE_VP_ROUTE = 9'h00c;
  // field positions
  localparam int EDGE_MSG_SET_BIT = 31;
  localparam int EDGE_MSG_IDX_LSB = 0;
  localparam int EDGE_MSG_IDX_W = 8;
  localparam int DEBUG_SEND_BIT = 0;
  localparam int PIN_ROUTE_W = 3;
  localparam logic [2:0] PIN_NMI = 3'h6;
  localparam int CFG_SRC_LSB = 0;
  localparam int CFG_VP_LSB = 16;
  // values
  localparam logic [7:0] CFG_SRC_FIELD = 8'h1f;
  localparam logic [7:0] CFG_VP_FIELD = 8'h03;
  localparam logic [31:0] REVISION_DEFAULT = 32'h0000_0100;
  localparam logic [63:0] CNT_STEP = 64'h1;
  localparam logic [31:0] READ_ZERO = 32'h0;

  typedef struct packed {
    logic valid;
    logic write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } gsr_req_t;

  typedef struct packed {
    logic [NUM_SRC-1:0] sync1;
    logic [NUM_SRC-1:0] sync2;
    logic [NUM_SRC-1:0] prev;
    logic [NUM_SRC-1:0] pol;
    logic [NUM_SRC-1:0] trig;
    logic [NUM_SRC-1:0] dual;
    logic [NUM_SRC-1:0] mask;
    logic [NUM_SRC-1:0] edge_det;
    logic [NUM_SRC-1:0][PIN_ROUTE_W-1:0] pin;
    logic [NUM_SRC-1:0][NUM_VP-1:0] vp;
    logic [63:0] count;
    logic dint;
    logic group;
    logic [NUM_VP-1:0] pdbg;
    logic [NUM_VP-1:0][NUM_LINES-1:0] ints;
    logic [NUM_VP-1:0] nmi;
    logic [DATA_W-1:0] rdata;
    logic rvalid;
    logic unmapped_rd;
  } gsr_state_t;
endpackage

// *** src/gsr_shared_regs.sv ***
// shared register section of the global interrupt controller
`timescale 1ns/1ps
module gsr_shared_regs #(
  // arbitrary value, not tied to any real part
  parameter logic [31:0] REVISION_ID = gsr_pkg::REVISION_DEFAULT
) (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire gsr_pkg::gsr_req_t i_req,
  input wire logic [gsr_pkg::NUM_SRC-1:0] i_src,
  input wire logic [gsr_pkg::NUM_VP-1:0] i_debug_part,
  output logic [gsr_pkg::DATA_W-1:0] o_rdata,
  output logic o_rvalid,
  output logic [gsr_pkg::NUM_VP-1:0][gsr_pkg::NUM_LINES-1:0] o_int,
  output logic [gsr_pkg::NUM_VP-1:0] o_nmi,
  output logic o_group_debug,
  output logic [gsr_pkg::NUM_VP-1:0] o_proc_debug
);
  import gsr_pkg::*;

  gsr_state_t state_r;
  gsr_state_t state_nxt;
  logic [NUM_SRC-1:0] ev_set;
  logic [NUM_SRC-1:0] pend_w;
  logic [NUM_SRC-1:0] act_w;
  logic wr;
  logic rd;
  logic aligned;
  logic [8:0] page;
  logic [4:0] tidx;
  logic [EDGE_MSG_IDX_W-1:0] msg_idx;

  // request decode; only word aligned addresses map anywhere
  // whole word access
  assign aligned = (i_req.addr[1:0] == 2'h0);
  assign wr = i_req.valid & i_req.write & aligned;
  assign rd = i_req.valid & ~i_req.write;
  assign page = i_req.addr[15:7];
  // one word per source, 32 words to a page
  assign tidx = i_req.addr[6:2];
  assign msg_idx = i_req.wdata[EDGE_MSG_IDX_LSB +: EDGE_MSG_IDX_W];

  // per-source edge detection and pending view
  // limitation: a pin pulse shorter than a clock may be lost
  genvar s;
  generate
    for (s = 0; s < NUM_SRC; s++) begin : g_src
      logic rise;
      logic fall;
      assign rise = state_r.sync2[s] & ~state_r.prev[s];
      assign fall = ~state_r.sync2[s] & state_r.prev[s];
      assign ev_set[s] = state_r.trig[s] & (state_r.dual[s] ? (rise | fall)
                         : (state_r.pol[s] ? rise : fall));
      assign pend_w[s] = state_r.trig[s] ? state_r.edge_det[s]
                         : ~(state_r.sync2[s] ^ state_r.pol[s]);
      assign act_w[s] = pend_w[s] & state_r.mask[s];
    end
  endgenerate

  // next state: sync, counter, register writes, reads and outputs
  always_comb begin
    state_nxt = state_r;
    // sync1 feeds only sync2; edges are seen on sync2 against prev
    state_nxt.sync1 = i_src;
    state_nxt.sync2 = state_r.sync1;
    state_nxt.prev = state_r.sync2;
    // free running counter, software may load it
    state_nxt.count = state_r.count + CNT_STEP;
    // every read answers a cycle later, mapped or not
    state_nxt.rvalid = rd;
    state_nxt.rdata = READ_ZERO;
    state_nxt.unmapped_rd = 1'b0;
    if (wr) begin
      case (i_req.addr)
        OFS_CNT_LO: state_nxt.count[31:0] = i_req.wdata;
        OFS_CNT_HI: state_nxt.count[63:32] = i_req.wdata;
        OFS_POLARITY: state_nxt.pol = i_req.wdata;
        OFS_TRIGGER: state_nxt.trig = i_req.wdata;
        OFS_DUAL_EDGE: state_nxt.dual = i_req.wdata;
        // message sets or clears one edge bit
        OFS_EDGE_MSG: begin
          if (msg_idx < EDGE_MSG_IDX_W'(NUM_SRC)) begin
            state_nxt.edge_det[msg_idx[4:0]] =
              i_req.wdata[EDGE_MSG_SET_BIT];
          end
        end
        OFS_MASK_CLR: state_nxt.mask = state_r.mask & ~i_req.wdata;
        OFS_MASK_SET: state_nxt.mask = state_r.mask | i_req.wdata;
        OFS_DEBUG_SEND: state_nxt.dint = i_req.wdata[DEBUG_SEND_BIT];
        default: begin
          if (page == PAGE_PIN_ROUTE) begin
            state_nxt.pin[tidx] = i_req.wdata[PIN_ROUTE_W-1:0];
          end
          if (page == PAGE_VP_ROUTE) begin
            state_nxt.vp[tidx] = i_req.wdata[NUM_VP-1:0];
          end
        end
      endcase
    end
    // a new edge beats a message clear in the same cycle
    state_nxt.edge_det = state_nxt.edge_det | ev_set;
    // read mux from current state; unused bits read zero
    // zero fields read zero
    if (rd) begin
      if (!aligned) begin
        state_nxt.unmapped_rd = 1'b1;
      end else begin
        case (i_req.addr)
          OFS_CONFIG: begin
            state_nxt.rdata[CFG_SRC_LSB +: 8] = CFG_SRC_FIELD;
            state_nxt.rdata[CFG_VP_LSB +: 8] = CFG_VP_FIELD;
          end
          OFS_CNT_LO: state_nxt.rdata = state_r.count[31:0];
          OFS_CNT_HI: state_nxt.rdata = state_r.count[63:32];
          OFS_REVISION: state_nxt.rdata = REVISION_ID;
          OFS_POLARITY: state_nxt.rdata = state_r.pol;
          OFS_TRIGGER: state_nxt.rdata = state_r.trig;
          OFS_DUAL_EDGE: state_nxt.rdata = state_r.dual;
          OFS_MASK_STAT: state_nxt.rdata = state_r.mask;
          OFS_PENDING: state_nxt.rdata = pend_w;
          OFS_EDGE_MSG, OFS_MASK_CLR, OFS_MASK_SET,
          OFS_DEBUG_SEND: state_nxt.rdata = READ_ZERO;
          default: begin
            if (page == PAGE_PIN_ROUTE) begin
              state_nxt.rdata[PIN_ROUTE_W-1:0] = state_r.pin[tidx];
            end else if (page == PAGE_VP_ROUTE) begin
              state_nxt.rdata[NUM_VP-1:0] = state_r.vp[tidx];
            end else begin
              state_nxt.unmapped_rd = 1'b1;
            end
          end
        endcase
      end
    end
    // route enabled pending sources to lines
    for (int v = 0; v < NUM_VP; v++) begin
      state_nxt.nmi[v] = 1'b0;
      state_nxt.ints[v] = '0;
      for (int k = 0; k < NUM_SRC; k++) begin
        if (act_w[k] && state_r.vp[k][v]) begin
          // code 7 parks a source on no line at all
          if (state_r.pin[k] == PIN_NMI) begin
            state_nxt.nmi[v] = 1'b1;
          end else if (state_r.pin[k] < 3'(NUM_LINES)) begin
            state_nxt.ints[v][state_r.pin[k]] = 1'b1;
          end
        end
      end
    end
    // group then each participating processor
    // the group level leads the cores by one cycle so
    // each core is gated by a settled group signal
    state_nxt.group = state_r.dint;
    state_nxt.pdbg = {NUM_VP{state_r.group}} & i_debug_part;
  end

  // one register for the whole state, cleared by the async reset
  // widths follow the source count
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  // every output is a state flop
  assign o_rdata = state_r.rdata;
  assign o_rvalid = state_r.rvalid;
  assign o_int = state_r.ints;
  assign o_nmi = state_r.nmi;
  assign o_group_debug = state_r.group;
  assign o_proc_debug = state_r.pdbg;

  // checks on the block's own behaviour
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);

  a_unmapped_zero: assert property (
    state_r.unmapped_rd |-> (o_rvalid && o_rdata == READ_ZERO))
    else $error("unmapped read not zero");
  a_mask_clear: assert property (
    (wr && i_req.addr == OFS_MASK_CLR) |=>
      ((state_r.mask & $past(i_req.wdata)) == '0) &&
      ((state_r.mask | $past(i_req.wdata)) ==
       ($past(state_r.mask) | $past(i_req.wdata))))
    else $error("mask clear wrong");
  a_mask_set: assert property (
    (wr && i_req.addr == OFS_MASK_SET) |=>
      (state_r.mask == ($past(state_r.mask) | $past(i_req.wdata))))
    else $error("mask set wrong");
  a_mask_read: assert property (
    (rd && i_req.addr == OFS_MASK_STAT) |=>
      (o_rvalid && o_rdata == $past(state_r.mask)))
    else $error("mask status read wrong");
  a_pend_read: assert property (
    (rd && i_req.addr == OFS_PENDING) |=>
      (o_rvalid && o_rdata == $past(pend_w)))
    else $error("pending read wrong");
  a_level_pol: assert property (
    (!state_r.trig[0] && $stable(state_r.pol[0]) &&
     $stable(state_r.trig[0])) |->
      (pend_w[0] == (state_r.sync2[0] == state_r.pol[0])))
    else $error("level polarity wrong");
  a_level_low: assert property (
    (!state_r.trig[0] && !state_r.pol[0] && !state_r.sync2[0]) |-> pend_w[0])
    else $error("active low level not pending");
  a_pend_unmasked: assert property (
    (!state_r.trig[0] && state_r.pol[0] && state_r.sync2[0] &&
     !state_r.mask[0]) |-> pend_w[0])
    else $error("masked source hidden from pending");
  a_rise_edge: assert property (
    (state_r.trig[1] && !state_r.dual[1] && state_r.pol[1] &&
     state_r.sync2[1] && !state_r.prev[1]) |=> state_r.edge_det[1])
    else $error("rising edge missed");
  a_fall_edge: assert property (
    (state_r.trig[1] && !state_r.dual[1] && !state_r.pol[1] &&
     !state_r.sync2[1] && state_r.prev[1]) |=> state_r.edge_det[1])
    else $error("falling edge missed");
  a_dual_edge: assert property (
    (state_r.trig[1] && state_r.dual[1] && !state_r.sync2[1] &&
     state_r.prev[1]) |=> state_r.edge_det[1])
    else $error("dual edge missed");
  a_dual_rise: assert property (
    (state_r.trig[1] && state_r.dual[1] && state_r.sync2[1] &&
     !state_r.prev[1]) |=> state_r.edge_det[1])
    else $error("dual rising edge missed");
  a_trig_write: assert property (
    (wr && i_req.addr == OFS_TRIGGER) |=>
      (state_r.trig == $past(i_req.wdata)))
    else $error("trigger type not stored");
  a_level_latch: assert property (
    (!state_r.trig[1] && !state_r.edge_det[1] &&
     !(wr && i_req.addr == OFS_EDGE_MSG)) |=> !state_r.edge_det[1])
    else $error("level source latched an edge");
  a_edge_stands: assert property (
    (state_r.edge_det[1] && !(wr && i_req.addr == OFS_EDGE_MSG)) |=>
      state_r.edge_det[1])
    else $error("edge bit dropped without clear");
  a_edge_msg: assert property (
    (wr && i_req.addr == OFS_EDGE_MSG && msg_idx == 8'h01) |=>
      (state_r.edge_det[1] == ($past(i_req.wdata[EDGE_MSG_SET_BIT]) |
                               $past(ev_set[1]))))
    else $error("edge message wrong");

  // routing toward the cores
  a_route_line: assert property (
    (act_w[0] && state_r.vp[0][0] && state_r.pin[0] == 3'h2) |=>
      o_int[0][2])
    else $error("routed line not raised");
  a_nmi_route: assert property (
    (act_w[1] && state_r.vp[1][1] && state_r.pin[1] == PIN_NMI) |=>
      o_nmi[1])
    else $error("nmi route not raised");
  a_pin_write: assert property (
    (wr && page == PAGE_PIN_ROUTE && tidx == 5'h00) |=>
      (state_r.pin[0] == $past(i_req.wdata[PIN_ROUTE_W-1:0])))
    else $error("pin route not stored");
  a_vp_write: assert property (
    (wr && page == PAGE_VP_ROUTE && tidx == 5'h00) |=>
      (state_r.vp[0] == $past(i_req.wdata[NUM_VP-1:0])))
    else $error("processor route not stored");
  a_no_target: assert property (
    (state_r.vp == '0) |=> (o_int == '0 && o_nmi == '0))
    else $error("line raised with no target");
  a_masked_quiet: assert property (
    (state_r.mask == '0) |=> (o_int == '0 && o_nmi == '0))
    else $error("masked source raised a line");

  // debug delivery
  a_debug_send: assert property (
    (wr && i_req.addr == OFS_DEBUG_SEND && i_req.wdata[DEBUG_SEND_BIT])
      |=> ##1 (o_group_debug ##1 (o_proc_debug == $past(i_debug_part))))
    else $error("debug send not delivered");
  a_dint_level: assert property (
    (wr && i_req.addr == OFS_DEBUG_SEND) |=>
      (state_r.dint == $past(i_req.wdata[DEBUG_SEND_BIT])))
    else $error("debug send level wrong");
  a_group_follow: assert property (
    (wr && i_req.addr == OFS_DEBUG_SEND && !i_req.wdata[DEBUG_SEND_BIT])
      |=> ##1 !o_group_debug)
    else $error("group debug not dropped");
  a_proc_gated: assert property (
    (o_proc_debug != '0) |-> $past(o_group_debug))
    else $error("core debug without group");

  // counter, read answers and protected words
  a_counter_run: assert property (
    !wr |=> (state_r.count == $past(state_r.count) + CNT_STEP))
    else $error("counter not running");
  a_counter_load: assert property (
    (wr && i_req.addr == OFS_CNT_HI) |=>
      (state_r.count[63:32] == $past(i_req.wdata)))
    else $error("counter high word not loaded");
  a_rdata_pol: assert property (
    (rd && i_req.addr == OFS_POLARITY) |=>
      (o_rvalid && o_rdata == $past(state_r.pol)))
    else $error("polarity read wrong");
  a_read_answer: assert property (
    rd |=> o_rvalid)
    else $error("read not answered");
  a_read_quiet: assert property (
    !o_rvalid |-> (o_rdata == READ_ZERO))
    else $error("read data not idle zero");
  a_unaligned_read: assert property (
    (rd && !aligned) |=> (o_rvalid && o_rdata == READ_ZERO))
    else $error("misaligned read not zero");
  a_cfg_read: assert property (
    (rd && i_req.addr == OFS_CONFIG) |=>
      (o_rvalid && o_rdata[CFG_SRC_LSB +: 8] == 8'(NUM_SRC - 1) &&
       o_rdata[CFG_VP_LSB +: 8] == 8'(NUM_VP - 1)))
    else $error("configuration read wrong");
  a_rev_read: assert property (
    (rd && i_req.addr == OFS_REVISION) |=> (o_rvalid && o_rdata == REVISION_ID))
    else $error("revision read wrong");
  a_ro_write: assert property (
    (wr && i_req.addr == OFS_CONFIG) |=>
      ($stable(state_r.mask) && $stable(state_r.pol) &&
       $stable(state_r.trig) && $stable(state_r.dual)))
    else $error("read-only write changed state");
  a_wo_read: assert property (
    (rd && (i_req.addr == OFS_EDGE_MSG || i_req.addr == OFS_DEBUG_SEND))
      |=> (o_rvalid && o_rdata == READ_ZERO))
    else $error("write-only read not zero");
  a_mask_hold: assert property (
    !(wr && (i_req.addr == OFS_MASK_SET || i_req.addr == OFS_MASK_CLR))
      |=> $stable(state_r.mask))
    else $error("mask changed without write");

  // main scenarios
  c_mask_set: cover property (wr && i_req.addr == OFS_MASK_SET);
  c_edge_pend: cover property (ev_set[1] ##1 pend_w[1]);
  c_nmi_out: cover property (o_nmi[1]);
  c_debug_out: cover property (o_group_debug ##1 o_proc_debug[1]);
  c_unmapped: cover property (state_r.unmapped_rd);
endmodule // gsr_shared_regs

// *** tb/global_interrupt_shared_regs_tb_top.sv ***
// self-checking bench for the shared interrupt register block
`timescale 1ns/1ps
module global_interrupt_shared_regs_tb_top;
  import gsr_pkg::*;
  logic i_clock;
  logic i_rst_n;
  gsr_req_t i_req;
  logic [NUM_SRC-1:0] i_src;
  logic [NUM_VP-1:0] part;
  logic [NUM_VP-1:0] seen;
  logic [DATA_W-1:0] o_rdata;
  logic o_rvalid;
  logic [NUM_VP-1:0][NUM_LINES-1:0] o_int;
  logic [NUM_VP-1:0] o_nmi;
  logic o_group_debug;
  logic [NUM_VP-1:0] o_proc_debug;
  int bad_count;
  int num_checks;
  logic [31:0] seed;
  logic [31:0] pol_m, trig_m, edge_m, mask_m, r;
  logic [31:0] exp_q[$];

  gsr_shared_regs uut (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_req(i_req),
    .i_src(i_src), .i_debug_part(part), .o_rdata(o_rdata),
    .o_rvalid(o_rvalid), .o_int(o_int), .o_nmi(o_nmi),
    .o_group_debug(o_group_debug), .o_proc_debug(o_proc_debug));
  gsr_cores_model cores (.i_clock(i_clock), .i_rst_n(i_rst_n),
    .i_proc_debug(o_proc_debug), .o_debug_part(part), .o_debug_seen(seen));

  initial begin
    i_clock = 1'b0;
    forever #4 i_clock = ~i_clock;
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // level sources follow the synced pin, edge sources their latch
  function automatic logic [31:0] pend_exp();
    return (~trig_m & ~(i_src ^ pol_m)) | (trig_m & edge_m);
  endfunction
  task automatic check(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      bad_count++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic close_out();
    if (exp_q.size() != 0) begin
      bad_count++;
      $display("MISMATCH t=%0t %0d reads never answered", $time, exp_q.size());
    end
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic acc(input logic w, input logic [15:0] a,
                     input logic [31:0] d);
    @(posedge i_clock);
    i_req <= '{valid: 1'b1, write: w, addr: a, wdata: d};
    @(posedge i_clock);
    i_req.valid <= 1'b0;
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    acc(1'b1, a, d);
  endtask
  task automatic rd(input logic [15:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    acc(1'b0, a, 32'h0);
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(posedge i_clock);
    #1;
  endtask
  // move source 1, then look at the nmi line and the pending view
  task automatic src1_to(input logic v, input logic hit);
    @(posedge i_clock);
    i_src[1] <= v;
    wait_n(6);
    if (hit) edge_m[1] = 1'b1;
    check({28'h0, o_nmi}, {28'h0, 2'h0, edge_m[1], 1'h0});
    rd(OFS_PENDING, pend_exp());
  endtask
  task automatic clr1();
    wr(OFS_EDGE_MSG, 32'h0000_0001);
    edge_m[1] = 1'b0;
    rd(OFS_PENDING, pend_exp());
  endtask

  // read answers are matched against the oldest note
  always @(posedge i_clock) begin
    if (o_rvalid === 1'b1) begin
      if (exp_q.size() == 0) begin
        bad_count++;
        $display("MISMATCH t=%0t read answer without request", $time);
      end else begin
        check(o_rdata, exp_q.pop_front());
      end
    end
  end

  // watchdog well beyond the expected run
  initial begin
    repeat (20000) @(posedge i_clock);
    bad_count++;
    close_out();
  end

  initial begin
    i_rst_n = 1'b0;
    i_req = '0;
    i_src = '0;
    bad_count = 0;
    num_checks = 0;
    seed = 32'h0000_003d;
    {pol_m, trig_m, edge_m, mask_m} = '0;
    repeat (10) @(posedge i_clock);
    i_rst_n <= 1'b1;
    wait_n(1);
    check({31'h0, o_group_debug}, 32'h0);
    rd(OFS_CONFIG, 32'h0003_001f);
    rd(OFS_REVISION, REVISION_DEFAULT);
    wr(OFS_CONFIG, 32'hffff_ffff);
    rd(OFS_CONFIG, 32'h0003_001f);
    wr(16'h0040, 32'hffff_ffff);
    rd(16'h0040, READ_ZERO);
    rd(16'h0402, READ_ZERO);
    rd(OFS_EDGE_MSG, READ_ZERO);
    rd(OFS_PENDING, pend_exp());
    wr(OFS_CNT_HI, 32'h0000_00a5);
    rd(OFS_CNT_HI, 32'h0000_00a5);
    // random polarity and pins against the pending view
    for (int k = 0; k < 4; k++) begin
      pol_m = rnd();
      wr(OFS_POLARITY, pol_m);
      rd(OFS_POLARITY, pol_m);
      r = rnd();
      wr(OFS_DUAL_EDGE, r);
      rd(OFS_DUAL_EDGE, r);
      @(posedge i_clock);
      i_src <= rnd();
      wait_n(5);
      rd(OFS_PENDING, pend_exp());
      r = rnd();
      wr(OFS_MASK_SET, r);
      mask_m = mask_m | r;
      r = rnd();
      wr(OFS_MASK_CLR, r);
      mask_m = mask_m & ~r;
      rd(OFS_MASK_STAT, mask_m);
    end
    wr(OFS_MASK_CLR, 32'hffff_ffff);
    wr(OFS_DUAL_EDGE, 32'h0);
    pol_m = 32'hffff_ffff;
    wr(OFS_POLARITY, pol_m);
    @(posedge i_clock);
    i_src <= '0;
    // level source 0 to line 2 of processors 0 and 2
    wr(16'h0500, 32'h2);
    rd(16'h0500, 32'h2);
    wr(16'h0600, 32'h5);
    rd(16'h0600, 32'h5);
    wr(OFS_MASK_SET, 32'h1);
    @(posedge i_clock);
    i_src[0] <= 1'b1;
    wait_n(5);
    check({8'h0, o_int}, 32'h0000_4004);
    wr(OFS_MASK_CLR, 32'h1);
    wait_n(3);
    check({8'h0, o_int}, 32'h0);
    rd(OFS_PENDING, pend_exp());
    // edge source 1 to the nmi line of processor 1
    wr(16'h0504, {29'h0, PIN_NMI});
    wr(16'h0604, 32'h2);
    trig_m = 32'h2;
    wr(OFS_TRIGGER, trig_m);
    wr(OFS_MASK_SET, 32'h2);
    src1_to(1'b1, 1'b1);
    src1_to(1'b0, 1'b0);
    clr1();
    wr(OFS_EDGE_MSG, 32'h8000_0001);
    edge_m[1] = 1'b1;
    rd(OFS_PENDING, pend_exp());
    clr1();
    pol_m[1] = 1'b0;
    wr(OFS_POLARITY, pol_m);
    src1_to(1'b1, 1'b0);
    src1_to(1'b0, 1'b1);
    clr1();
    wr(OFS_DUAL_EDGE, 32'h2);
    src1_to(1'b1, 1'b1);
    clr1();
    src1_to(1'b0, 1'b1);
    clr1();
    // debug send to participating processors
    cores.set_part(4'ha);
    wr(OFS_DEBUG_SEND, 32'h1);
    wait_n(4);
    check({31'h0, o_group_debug}, 32'h1);
    check({28'h0, o_proc_debug}, 32'ha);
    check({28'h0, seen}, 32'ha);
    rd(OFS_DEBUG_SEND, READ_ZERO);
    wr(OFS_DEBUG_SEND, 32'h0);
    wait_n(4);
    check({27'h0, o_group_debug, o_proc_debug}, 32'h0);
    wait_n(4);
    close_out();
  end
endmodule // global_interrupt_shared_regs_tb_top

// *** tb/gsr_cores_model.sv ***
// processor cores model standing behind the routed debug lines
`timescale 1ns/1ps
module gsr_cores_model (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic [gsr_pkg::NUM_VP-1:0] i_proc_debug,
  output logic [gsr_pkg::NUM_VP-1:0] o_debug_part,
  output logic [gsr_pkg::NUM_VP-1:0] o_debug_seen
);
  import gsr_pkg::*;
  logic [NUM_VP-1:0] prev_r;
  initial o_debug_part = '0;
  task automatic set_part(input logic [NUM_VP-1:0] v);
    @(posedge i_clock);
    o_debug_part <= v;
  endtask
  // sticky record so a short request is not missed
  always @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      prev_r <= '0;
      o_debug_seen <= '0;
    end else begin
      prev_r <= i_proc_debug;
      o_debug_seen <= o_debug_seen | (i_proc_debug & ~prev_r);
    end
  end
endmodule // gsr_cores_model
